// >>> pkg/rxs_pkg.sv
`default_nettype none
package rxs_pkg;

	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h06;
	localparam logic [7:0] OFF_IRQ_EN = 8'h07;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_DATA_A = 8'h09;
	localparam logic [7:0] OFF_VALID_A = 8'h0A;
	localparam logic [7:0] OFF_DATA_B = 8'h0B;
	localparam logic [7:0] OFF_VALID_B = 8'h0C;

	// Values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// Control register layout, upper nibble reserved
	localparam logic [7:0] CTRL_MASK = 8'h0F;
	localparam int EOF_LEN_LSB = 0;
	localparam int EOF_LEN_W = 3;

	// Per-channel nibble of enable and status registers
	localparam int NUM_CH = 2;
	localparam int CH_FIELD_W = 4;
	localparam int EN_FULL = 0;
	localparam int EN_EOF = 1;
	localparam int EN_OVF = 2;
	localparam int EN_UDF = 3;
	localparam int ST_FULL = 0;
	localparam int ST_EOF = 1;
	localparam int ST_FLOW = 2;
	localparam int ST_VALID = 3;

	// Byte assembly counts
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] GAP_ZERO = 3'h0;

	// Frame tracking
	typedef enum logic {FRM_IDLE, FRM_RUN} rxs_frm_t;

endpackage : rxs_pkg
`default_nettype wire

// >>> pkg/rxs_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rxs_chan_if;
	logic [2:0] eof_len;
	logic rx_mode;
	logic rd_data;
	logic load;
	logic eof;
	logic ovf;
	logic held;
	logic [7:0] data;
	logic [7:0] vmask;

	modport chan (
		input eof_len, rx_mode, rd_data,
		output load, eof, ovf, held, data, vmask
	);
	modport ctl (
		output eof_len, rx_mode, rd_data,
		input load, eof, ovf, held, data, vmask
	);
endinterface : rxs_chan_if
`default_nettype wire

// >>> core/rxs_chan.sv
`timescale 1ns/1ps
`default_nettype none
module rxs_chan (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Receiver bit stream
	input wire logic bit_tick,
	input wire logic bit_valid,
	input wire logic bit_data,
	// Control side
	rxs_chan_if.chan ch
);
	rxs_pkg::rxs_frm_t frm_r, frm_nxt;
	logic [2:0] nbits_r, nbits_nxt;
	logic [2:0] ninv_r, ninv_nxt;
	logic [7:0] shf_r, shf_nxt;
	logic [7:0] shm_r, shm_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic held_r, held_nxt;
	logic load_r, load_nxt;
	logic eof_r, eof_nxt;
	logic ovf_r, ovf_nxt;
	logic take;
	logic move;
	logic [7:0] newd;
	logic [7:0] newm;

	always_comb begin
		frm_nxt = frm_r;
		nbits_nxt = nbits_r;
		ninv_nxt = ninv_r;
		shf_nxt = shf_r;
		shm_nxt = shm_r;
		data_nxt = data_r;
		mask_nxt = mask_r;
		held_nxt = held_r;
		load_nxt = 1'b0;
		eof_nxt = 1'b0;
		ovf_nxt = 1'b0;
		take = 1'b0;
		move = 1'b0;
		newd = shf_r;
		newm = shm_r;
		if (ch.rd_data) begin
			held_nxt = 1'b0;
		end
		if (!ch.rx_mode) begin
			frm_nxt = rxs_pkg::FRM_IDLE;
			nbits_nxt = rxs_pkg::BIT_FIRST;
			ninv_nxt = rxs_pkg::GAP_ZERO;
			shf_nxt = rxs_pkg::DATA_RST;
			shm_nxt = rxs_pkg::DATA_RST;
		end else if (bit_tick) begin
			unique case (frm_r)
				rxs_pkg::FRM_IDLE: take = bit_valid;
				rxs_pkg::FRM_RUN: take = 1'b1;
			endcase
		end
		if (take) begin
			frm_nxt = rxs_pkg::FRM_RUN;
			newd[nbits_r] = bit_data;
			newm[nbits_r] = bit_valid;
			nbits_nxt = nbits_r + 3'h1;
			ninv_nxt = bit_valid ? rxs_pkg::GAP_ZERO : ninv_r + 3'h1;
			if (!bit_valid && ninv_r >= ch.eof_len) begin
				eof_nxt = 1'b1;
				frm_nxt = rxs_pkg::FRM_IDLE;
				ninv_nxt = rxs_pkg::GAP_ZERO;
			end
			move = (nbits_r == rxs_pkg::BIT_LAST) || eof_nxt;
			shf_nxt = move ? rxs_pkg::DATA_RST : newd;
			shm_nxt = move ? rxs_pkg::DATA_RST : newm;
			if (move) begin
				nbits_nxt = rxs_pkg::BIT_FIRST;
				data_nxt = newd;
				mask_nxt = newm;
				load_nxt = 1'b1;
				ovf_nxt = held_r && !ch.rd_data;
				held_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frm_r <= rxs_pkg::FRM_IDLE;
			nbits_r <= rxs_pkg::BIT_FIRST;
			ninv_r <= rxs_pkg::GAP_ZERO;
			shf_r <= rxs_pkg::DATA_RST;
			shm_r <= rxs_pkg::DATA_RST;
			data_r <= rxs_pkg::DATA_RST;
			mask_r <= rxs_pkg::DATA_RST;
			held_r <= 1'b0;
			load_r <= 1'b0;
			eof_r <= 1'b0;
			ovf_r <= 1'b0;
		end else begin
			frm_r <= frm_nxt;
			nbits_r <= nbits_nxt;
			ninv_r <= ninv_nxt;
			shf_r <= shf_nxt;
			shm_r <= shm_nxt;
			data_r <= data_nxt;
			mask_r <= mask_nxt;
			held_r <= held_nxt;
			load_r <= load_nxt;
			eof_r <= eof_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	assign ch.load = load_r;
	assign ch.eof = eof_r;
	assign ch.ovf = ovf_r;
	assign ch.held = held_r;
	assign ch.data = data_r;
	assign ch.vmask = mask_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_eof_zero_len: assert property ((ch.rx_mode && ch.eof_len == 3'h0 &&
		frm_r == rxs_pkg::FRM_RUN && bit_tick && !bit_valid) |=> ch.eof)
		else $error("zero gap length missed end of frame");
	a_eof_after_start: assert property (ch.eof |-> $past(frm_r) == rxs_pkg::FRM_RUN)
		else $error("end of frame without a started frame");
	a_eof_loads_byte: assert property (ch.eof |-> (ch.load && ch.held))
		else $error("end of frame did not move the partial byte");
	a_ovf_cause: assert property (ch.ovf |-> (ch.load && $past(held_r)))
		else $error("overflow without a byte over unread data");
endmodule : rxs_chan
`default_nettype wire

// >>> core/rxs_irq_status.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Enable bit 3 gates channel A underflow
// - Reading empty data register flags underflow
// - Enable bit 2 gates channel A overflow
// - Byte loaded over unread byte flags overflow
// - Enable bit 1 gates channel A end-of-frame
// - End of frame after gap exceeds length
// - Zero length ends at first invalid bit
// - End-of-frame flag cleared by status read
// - Enable bit 0 gates channel A full
// - Full on complete byte or end-of-frame
// - Status bit 7 all-valid B, no interrupt
// - Status bit 6 channel B flow violation
// - Status bit 5 channel B end-of-frame
// - Status read clears flow and end-of-frame
// - Status pollable, zero outside receive mode
// - Three-bit end-of-frame length in control
module rxs_irq_status (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Operating mode
	input wire logic rx_mode,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Receiver bit streams, index 0 is channel A
	input wire logic [1:0] rx_bit_tick,
	input wire logic [1:0] rx_bit_valid,
	input wire logic [1:0] rx_bit_data,
	// Interrupt
	output logic irq
);
	localparam int NCH = rxs_pkg::NUM_CH;
	localparam int FW = rxs_pkg::CH_FIELD_W;

	// Register hit on a given offset
	function automatic logic rxs_hit(
		input logic [7:0] addr,
		input logic [7:0] off,
		input logic strobe
	);
		rxs_hit = strobe && (addr == off);
	endfunction : rxs_hit

	// One channel's nibble of the status register
	function automatic logic [3:0] rxs_ch_stat(
		input logic held,
		input logic eof,
		input logic flow,
		input logic vall
	);
		logic [3:0] s;
		s = 4'h0;
		s[rxs_pkg::ST_FULL] = held;
		s[rxs_pkg::ST_EOF] = eof;
		s[rxs_pkg::ST_FLOW] = flow;
		s[rxs_pkg::ST_VALID] = vall;
		rxs_ch_stat = s;
	endfunction : rxs_ch_stat

	// One channel's enabled request
	function automatic logic rxs_ch_irq(
		input logic [3:0] en,
		input logic held,
		input logic eof,
		input logic ovf,
		input logic udf
	);
		rxs_ch_irq = (held && en[rxs_pkg::EN_FULL]) ||
			(eof && en[rxs_pkg::EN_EOF]) ||
			(ovf && en[rxs_pkg::EN_OVF]) ||
			(udf && en[rxs_pkg::EN_UDF]);
	endfunction : rxs_ch_irq

	// Register state
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] en_r, en_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;

	// Pending flags per channel
	logic [NCH-1:0] eof_pend_r, eof_pend_nxt;
	logic [NCH-1:0] ovf_pend_r, ovf_pend_nxt;
	logic [NCH-1:0] udf_pend_r, udf_pend_nxt;

	// Channel views
	logic [NCH-1:0] held;
	logic [NCH-1:0] eof_in;
	logic [NCH-1:0] ovf_in;
	logic [NCH-1:0] vall;
	logic [NCH-1:0] rd_dat;
	logic [NCH-1:0] udf_evt;
	logic [7:0] dat [NCH];
	logic [7:0] msk [NCH];

	// Decoded accesses
	logic rd_stat;
	logic [7:0] stat;
	logic [2:0] eof_len;

	rxs_chan_if ch_if [NCH] ();

	assign eof_len = ctrl_r[rxs_pkg::EOF_LEN_LSB +: rxs_pkg::EOF_LEN_W];

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign ch_if[g].eof_len = eof_len;
			assign ch_if[g].rx_mode = rx_mode;
			assign ch_if[g].rd_data = rd_dat[g];
			assign held[g] = ch_if[g].held;
			assign eof_in[g] = ch_if[g].eof;
			assign ovf_in[g] = ch_if[g].ovf;
			assign dat[g] = ch_if[g].data;
			assign msk[g] = ch_if[g].vmask;
			assign vall[g] = ch_if[g].held && (&ch_if[g].vmask);
			rxs_chan u_chan (
				.sys_clk(sys_clk),
				.rst(rst),
				.bit_tick(rx_bit_tick[g]),
				.bit_valid(rx_bit_valid[g]),
				.bit_data(rx_bit_data[g]),
				.ch(ch_if[g])
			);
		end
	endgenerate

	// Access decode
	always_comb begin
		rd_stat = rxs_hit(reg_addr, rxs_pkg::OFF_STAT, reg_rd);
		rd_dat[0] = rxs_hit(reg_addr, rxs_pkg::OFF_DATA_A, reg_rd);
		rd_dat[1] = rxs_hit(reg_addr, rxs_pkg::OFF_DATA_B, reg_rd);
		for (int c = 0; c < NCH; c++) begin
			udf_evt[c] = rd_dat[c] && !held[c] && rx_mode;
		end
	end

	// Status byte, zero outside receive mode
	always_comb begin
		stat = rxs_pkg::STAT_RST;
		if (rx_mode) begin
			for (int c = 0; c < NCH; c++) begin
				stat[c*FW +: FW] = rxs_ch_stat(held[c], eof_pend_r[c],
					ovf_pend_r[c] || udf_pend_r[c], vall[c]);
			end
		end
	end

	// Pending flags, a new event wins over the read clear
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			eof_pend_nxt[c] = eof_in[c] || (eof_pend_r[c] && !rd_stat);
			ovf_pend_nxt[c] = ovf_in[c] || (ovf_pend_r[c] && !rd_stat);
			udf_pend_nxt[c] = udf_evt[c] || (udf_pend_r[c] && !rd_stat);
		end
	end

	// Interrupt request
	always_comb begin
		irq_nxt = 1'b0;
		if (rx_mode) begin
			for (int c = 0; c < NCH; c++) begin
				if (rxs_ch_irq(en_r[c*FW +: FW], held[c], eof_pend_r[c],
					ovf_pend_r[c], udf_pend_r[c])) begin
					irq_nxt = 1'b1;
				end
			end
		end
	end

	// Register writes
	always_comb begin
		ctrl_nxt = ctrl_r;
		en_nxt = en_r;
		if (rxs_hit(reg_addr, rxs_pkg::OFF_CTRL, reg_wr)) begin
			ctrl_nxt = reg_wdata & rxs_pkg::CTRL_MASK;
		end
		if (rxs_hit(reg_addr, rxs_pkg::OFF_IRQ_EN, reg_wr)) begin
			en_nxt = reg_wdata;
		end
	end

	// Register reads
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				rxs_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
				rxs_pkg::OFF_IRQ_EN: rdata_nxt = en_r;
				rxs_pkg::OFF_STAT: rdata_nxt = stat;
				rxs_pkg::OFF_DATA_A: rdata_nxt = dat[0];
				rxs_pkg::OFF_VALID_A: rdata_nxt = msk[0];
				rxs_pkg::OFF_DATA_B: rdata_nxt = dat[1];
				rxs_pkg::OFF_VALID_B: rdata_nxt = msk[1];
				default: rdata_nxt = rxs_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_r <= rxs_pkg::CTRL_RST;
			en_r <= rxs_pkg::IRQ_EN_RST;
			rdata_r <= rxs_pkg::RDATA_RST;
			irq_r <= 1'b0;
			eof_pend_r <= '0;
			ovf_pend_r <= '0;
			udf_pend_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			en_r <= en_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			eof_pend_r <= eof_pend_nxt;
			ovf_pend_r <= ovf_pend_nxt;
			udf_pend_r <= udf_pend_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq = irq_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_stat_rd;
		reg_rd && reg_addr == rxs_pkg::OFF_STAT;
	endsequence

	sequence s_quiet_a;
		!eof_in[0] && !ovf_in[0] && !udf_evt[0];
	endsequence

	sequence s_full_a_armed;
		held[0] && en_r[rxs_pkg::EN_FULL] && rx_mode;
	endsequence

	a_udf_flag: assert property ((rd_dat[0] && !held[0] && rx_mode) |=> udf_pend_r[0])
		else $error("underflow not flagged on empty read");
	a_read_clears: assert property ((s_stat_rd and s_quiet_a) |=>
		(eof_pend_r[0] == 1'b0 && ovf_pend_r[0] == 1'b0 && udf_pend_r[0] == 1'b0))
		else $error("status read did not clear pending flags");
	a_eof_hold: assert property ((eof_pend_r[0] && !reg_rd) |=> eof_pend_r[0])
		else $error("end of frame flag lost without a status read");
	a_ovf_irq: assert property ((ovf_pend_r[0] && en_r[rxs_pkg::EN_OVF] && rx_mode)
		|=> irq_r)
		else $error("enabled overflow gave no interrupt");
	a_udf_irq: assert property ((udf_pend_r[0] && en_r[rxs_pkg::EN_UDF] && rx_mode)
		|=> irq_r)
		else $error("enabled underflow gave no interrupt");
	a_eof_irq: assert property ((eof_pend_r[0] && en_r[rxs_pkg::EN_EOF] && rx_mode)
		|=> irq_r)
		else $error("enabled end of frame gave no interrupt");
	a_full_irq: assert property (s_full_a_armed |=> irq_r)
		else $error("enabled full gave no interrupt");
	a_valid_no_irq: assert property ((rx_mode && vall[1] && en_r == 8'h80 &&
		!udf_pend_r[1]) |=> !irq_r)
		else $error("all-valid status raised an interrupt");
	a_idle_zero: assert property ((s_stat_rd and !rx_mode) |=>
		reg_rdata == rxs_pkg::STAT_RST)
		else $error("status not zero outside receive mode");
	a_irq_idle: assert property (!rx_mode |=> !irq_r)
		else $error("interrupt outside receive mode");
	a_flow_b: assert property ((ovf_in[1] && rx_mode) |=> ##1 (stat[6] || !rx_mode ||
		$past(rd_stat)))
		else $error("channel B overflow not shown in status");
	a_ovf_flag: assert property (ovf_in[0] |=> ovf_pend_r[0])
		else $error("overflow pulse not kept pending");
	a_eof_flag: assert property (eof_in[0] |=> eof_pend_r[0])
		else $error("end of frame pulse not kept pending");
	a_full_a_stat: assert property ((held[0] && rx_mode) |-> stat[rxs_pkg::ST_FULL])
		else $error("channel A full not shown in status");
	a_irq_none: assert property ((en_r == rxs_pkg::IRQ_EN_RST) |=> !irq_r)
		else $error("interrupt with every enable off");

	// Channel B flags and status
	sequence s_quiet_b;
		!eof_in[1] && !ovf_in[1] && !udf_evt[1];
	endsequence

	a_read_clears_b: assert property ((s_stat_rd and s_quiet_b) |=>
		(eof_pend_r[1] == 1'b0 && ovf_pend_r[1] == 1'b0 && udf_pend_r[1] == 1'b0))
		else $error("status read did not clear channel B flags");
	a_udf_flag_b: assert property ((rd_dat[1] && !held[1] && rx_mode) |=>
		udf_pend_r[1])
		else $error("channel B underflow not flagged on empty read");
	a_flow_b_udf: assert property ((udf_pend_r[1] && rx_mode) |->
		stat[FW + rxs_pkg::ST_FLOW])
		else $error("channel B underflow not shown in status");
	a_eof_b_stat: assert property ((eof_pend_r[1] && rx_mode) |->
		stat[FW + rxs_pkg::ST_EOF])
		else $error("channel B end of frame not shown in status");
	a_full_b_stat: assert property ((held[1] && rx_mode) |->
		stat[FW + rxs_pkg::ST_FULL])
		else $error("channel B full not shown in status");
	a_valid_b_stat: assert property ((rx_mode && held[1] && msk[1] == 8'hFF) |->
		stat[FW + rxs_pkg::ST_VALID])
		else $error("channel B all-valid not shown in status");
	a_eof_b_irq: assert property ((eof_pend_r[1] && rx_mode &&
		en_r[FW + rxs_pkg::EN_EOF]) |=> irq_r)
		else $error("enabled channel B end of frame gave no interrupt");
	a_udf_b_irq: assert property ((udf_pend_r[1] && rx_mode &&
		en_r[FW + rxs_pkg::EN_UDF]) |=> irq_r)
		else $error("enabled channel B underflow gave no interrupt");
endmodule : rxs_irq_status
`default_nettype wire

// >>> test/rxs_host.sv
`timescale 1ns/1ps
`default_nettype none
module rxs_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One write strobe, lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// One read strobe, data taken once registered
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
endmodule : rxs_host
`default_nettype wire

// >>> test/rx_serdes_irq_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module rx_serdes_irq_status_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic rx_mode = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, irq;
	logic [1:0] rx_bit_tick = 2'h0;
	logic [1:0] rx_bit_valid = 2'h0;
	logic [1:0] rx_bit_data = 2'h0;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] seed = 32'd48468;
	int frm[2], pos[2], gap[2];
	logic [7:0] sh[2] = '{8'h00, 8'h00}, mk[2] = '{8'h00, 8'h00};
	logic [7:0] dat[2] = '{8'h00, 8'h00}, vm[2] = '{8'h00, 8'h00};
	logic [7:0] ctrl_m = 8'h00;
	logic [7:0] en_m = 8'h00;
	bit held[2], eofp[2], ovf[2], udf[2];

	always #10 sys_clk = ~sys_clk;

	rxs_irq_status uut (.sys_clk(sys_clk), .rst(rst), .rx_mode(rx_mode), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_bit_tick(rx_bit_tick), .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data),
		.irq(irq));
	rxs_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [3:0] nib(input int c);
		return {held[c] && vm[c] == 8'hFF, ovf[c] | udf[c], eofp[c], held[c]};
	endfunction : nib

	function automatic void load(input int c);
		ovf[c] = ovf[c] | held[c];
		held[c] = 1'b1;
		dat[c] = sh[c];
		vm[c] = mk[c];
		pos[c] = 0;
	endfunction : load

	function automatic void model_bit(input int c, input bit v, input bit d);
		if (!rx_mode || (!frm[c] && !v)) return;
		if (!frm[c]) begin
			frm[c] = 1;
			pos[c] = 0;
			gap[c] = 0;
		end
		if (pos[c] == 0) begin
			sh[c] = 8'h00;
			mk[c] = 8'h00;
		end
		sh[c][pos[c]] = d;
		mk[c][pos[c]] = v;
		if (!v && gap[c] >= ctrl_m[2:0]) begin
			frm[c] = 0;
			eofp[c] = 1'b1;
			load(c);
		end else begin
			gap[c] = v ? 0 : gap[c] + 1;
			if (pos[c] == 7) load(c);
			else pos[c]++;
		end
	endfunction : model_bit

	function automatic logic [7:0] model_read(input logic [7:0] a);
		int c;
		logic [7:0] r;
		c = (a == rxs_pkg::OFF_DATA_B || a == rxs_pkg::OFF_VALID_B) ? 1 : 0;
		r = 8'h00;
		if (a == rxs_pkg::OFF_CTRL) r = ctrl_m & rxs_pkg::CTRL_MASK;
		if (a == rxs_pkg::OFF_IRQ_EN) r = en_m;
		if (a == rxs_pkg::OFF_VALID_A || a == rxs_pkg::OFF_VALID_B) r = vm[c];
		if (a == rxs_pkg::OFF_STAT) begin
			if (rx_mode) r = {nib(1), nib(0)};
			eofp = '{0, 0};
			ovf = '{0, 0};
			udf = '{0, 0};
		end
		if (a == rxs_pkg::OFF_DATA_A || a == rxs_pkg::OFF_DATA_B) begin
			r = dat[c];
			udf[c] = udf[c] | (!held[c] && rx_mode);
			held[c] = 1'b0;
		end
		return r;
	endfunction : model_read

	task automatic settle();
		logic [7:0] pend;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		pend = {nib(1), nib(0)} & 8'h33;
		pend |= {udf[1], 3'h0, udf[0], 3'h0} | {1'b0, ovf[1], 3'h0, ovf[0], 2'h0};
		`CHK("irq", rx_mode && |(pend & en_m), irq)
	endtask : settle

	task automatic do_rd(input logic [7:0] a);
		logic [7:0] ex, got;
		ex = model_read(a);
		host.rd(a, got);
		`CHK("reg_rdata", ex, got)
		settle();
	endtask : do_rd

	task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		if (a == rxs_pkg::OFF_CTRL) ctrl_m = d;
		if (a == rxs_pkg::OFF_IRQ_EN) en_m = d;
		settle();
	endtask : do_wr

	task automatic send_bit(input int c, input bit v, input bit d);
		@(posedge sys_clk);
		rx_bit_tick[c] <= 1'b1;
		rx_bit_valid[c] <= v;
		rx_bit_data[c] <= d;
		@(posedge sys_clk);
		rx_bit_tick[c] <= 1'b0;
		rx_bit_valid[c] <= ~v;
		rx_bit_data[c] <= ~d;
		model_bit(c, v, d);
		settle();
	endtask : send_bit

	task automatic tally_and_finish();
		if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	initial begin
		logic [31:0] r;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rx_mode <= 1'b1;
		for (int a = 6; a < 14; a++) do_rd(8'(a));
		do_wr(rxs_pkg::OFF_IRQ_EN, 8'hFF);
		for (int len = 0; len < 8; len++) begin
			do_wr(rxs_pkg::OFF_CTRL, {5'h1F, 3'(len)});
			send_bit(len % 2, 1'b1, rnd() & 1);
			for (int k = 0; k <= len; k++) begin
				send_bit(len % 2, 1'b0, rnd() & 1);
				do_rd(rxs_pkg::OFF_STAT);
			end
		end
		do_wr(rxs_pkg::OFF_IRQ_EN, 8'h80);
		for (int k = 0; k < 8; k++) send_bit(1, 1'b1, rnd() & 1);
		do_rd(rxs_pkg::OFF_STAT);
		do_wr(rxs_pkg::OFF_IRQ_EN, 8'hFF);
		for (int i = 0; i < 1500; i++) begin
			r = rnd();
			case (r[2:0])
				3'h4: do_rd(rxs_pkg::OFF_STAT);
				3'h5: do_rd(r[13] ? 8'(6 + r[10:8]) : r[23:16]);
				3'h6: do_wr(r[13] ? 8'(6 + r[10:8]) : r[23:16], r[31:24]);
				3'h7: do_rd(r[8] ? rxs_pkg::OFF_DATA_B : rxs_pkg::OFF_DATA_A);
				default: send_bit(r[8], r[11:9] > 3'h2, r[12]);
			endcase
		end
		do_rd(rxs_pkg::OFF_STAT);
		@(posedge sys_clk);
		rx_mode <= 1'b0;
		frm = '{0, 0};
		settle();
		do_rd(rxs_pkg::OFF_STAT);
		send_bit(0, 1'b1, 1'b1);
		@(posedge sys_clk);
		rx_mode <= 1'b1;
		settle();
		do_rd(rxs_pkg::OFF_STAT);
		tally_and_finish();
	end
endmodule : rx_serdes_irq_status_tb
`default_nettype wire
